// File: dctom_monitor.v
// dctom_monitor.v - dual channel safe_torque_off input monitor
// assumes shutdown inputs are raw pins; rst is the power-on reset
//
// Operation
// - two separate shutdown inputs, evaluated as independent channels
// - both off within skew: disable power stage, coast, raise error
// - coordinated shutdown re-enables only after fault reset command
// - one input off or skew one second or more: disable, discrepancy error
// - discrepancy error ignores fault reset; only power cycle clears it
// - shutdown inputs always use source-type polarity, not the digital input setting
// - input active when sourced current flows in, otherwise inactive
// - torque removal does not depend on any motion feedback
`include "dctom_regs.vh"
`default_nettype none

module dctom_monitor #(
   parameter [`DCTOM_CNT_W-1:0] SKEW_LIMIT_CYC = `DCTOM_SKEW_LIMIT_CYC
) (
   input wire clk,
   input wire rst,
   input wire shutdown_in_chan_a,
   input wire shutdown_in_chan_b,
   input wire fault_reset,
   input wire brake_delay_req,
   output reg power_stage_en,
   output reg torque_off_err,
   output reg discrepancy_err,
   output reg brake_release,
   output reg fault_reset_ignored
);

   ////////////////////////////////////////////////////////////////////////
   // state codes and counter constants

   localparam [1:0] ST_RUN = 2'h0;
   localparam [1:0] ST_SKEW = 2'h1;
   localparam [1:0] ST_COORD = 2'h2;
   localparam [1:0] ST_DISCR = 2'h3;
   localparam [`DCTOM_CNT_W-1:0] CNT_ZERO = {`DCTOM_CNT_W{1'b0}};
   localparam [`DCTOM_CNT_W-1:0] CNT_ONE = {{(`DCTOM_CNT_W-1){1'b0}}, 1'b1};

   ////////////////////////////////////////////////////////////////////////
   // channel decode and skew limit helpers

   // both channels sourcing current
   function both_on;
      input a_in;
      input b_in;
      begin
         both_on = a_in & b_in;
      end
   endfunction

   // both channels without current
   function both_off;
      input a_in;
      input b_in;
      begin
         both_off = ~a_in & ~b_in;
      end
   endfunction

   // exactly one channel without current
   function one_off;
      input a_in;
      input b_in;
      begin
         one_off = a_in ^ b_in;
      end
   endfunction

   // skew counter at or past its limit
   function limit_hit;
      input [`DCTOM_CNT_W-1:0] cnt_in;
      input [`DCTOM_CNT_W-1:0] lim_in;
      begin
         limit_hit = (cnt_in >= lim_in);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers

   wire a_on;
   wire b_on;

   // source-type only: high level means current flows
   dctom_sync u_sync_a (
      .clk(clk),
      .rst(rst),
      .din(shutdown_in_chan_a),
      .dout(a_on)
   );

   dctom_sync u_sync_b (
      .clk(clk),
      .rst(rst),
      .din(shutdown_in_chan_b),
      .dout(b_on)
   );

   ////////////////////////////////////////////////////////////////////////
   // arming

   reg armed_q;

   // power-up needs both channels active once before enabling
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         armed_q <= 1'b0;
      end else if (both_on(a_on, b_on)) begin
         armed_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state machine

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [`DCTOM_CNT_W-1:0] cnt_q;
   reg [`DCTOM_CNT_W-1:0] cnt_d;
   wire skew_over;

   assign skew_over = limit_hit(cnt_q, SKEW_LIMIT_CYC);

   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         ST_RUN: begin
            cnt_d = CNT_ZERO;
            if (armed_q && both_off(a_on, b_on)) begin
               state_d = ST_COORD;
            end else if (armed_q && one_off(a_on, b_on)) begin
               state_d = ST_SKEW;
               cnt_d = CNT_ONE;
            end
         end
         ST_SKEW: begin
            if (both_off(a_on, b_on)) begin
               state_d = ST_COORD;
            end else if (skew_over) begin
               state_d = ST_DISCR;
            end else begin
               cnt_d = cnt_q + CNT_ONE;
            end
         end
         ST_COORD: begin
            // leave only on fault reset with both channels active
            if (fault_reset && both_on(a_on, b_on)) begin
               state_d = ST_RUN;
            end
         end
         ST_DISCR: begin
            state_d = ST_DISCR;
         end
         default: begin
            state_d = ST_DISCR;
         end
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_RUN;
         cnt_q <= CNT_ZERO;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power stage and brake, no motion feedback involved

   wire run_d;

   assign run_d = (state_d == ST_RUN) && armed_q && both_on(a_on, b_on);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         power_stage_en <= 1'b0;
      end else begin
         power_stage_en <= run_d;
      end
   end

   // brake delay request ignored once torque-off trips
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         brake_release <= 1'b0;
      end else begin
         brake_release <= run_d && !brake_delay_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // error indications

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         torque_off_err <= 1'b0;
         discrepancy_err <= 1'b0;
      end else begin
         torque_off_err <= (state_d == ST_COORD);
         discrepancy_err <= (state_d == ST_DISCR);
      end
   end

   // fault reset refused while discrepancy is latched
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_reset_ignored <= 1'b0;
      end else begin
         fault_reset_ignored <= fault_reset && (state_q == ST_DISCR);
      end
   end

endmodule

`default_nettype wire

// File: dctom_regs.vh
// dctom_regs.vh - constants for the dual channel torque-off monitor
// assumes a 100 MHz system clock; included by bare name
`ifndef DCTOM_REGS_VH
`define DCTOM_REGS_VH

// one second of system clock cycles
`define DCTOM_SKEW_LIMIT_CYC 27'h5F5E100
`define DCTOM_CNT_W 27

`endif

// File: dctom_sync.v
// dctom_sync.v - two flip-flop synchroniser for one pin level
// assumes din is asynchronous to clk
`default_nettype none

module dctom_sync (
   input wire clk,
   input wire rst,
   input wire din,
   output reg dout
);

   reg meta_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end

endmodule

`default_nettype wire

// File: dctom_relay.sv
// dctom_relay.sv - emergency stop relay model for both channels
// set acts at the next falling edge; high = current sourced
`default_nettype none
module dctom_relay (
   input wire logic clk,
   output var logic chan_a,
   output var logic chan_b
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      chan_a = 1'b1;
      chan_b = 1'b1;
   end
   // skew kept under the limit except on purpose
   task automatic set(input logic [1:0] ab);
      @(negedge clk);
      chan_a = ab[1];
      chan_b = ab[0];
   endtask
endmodule
`default_nettype wire

// File: dctom_checker.sv
// dctom_checker.sv - port assertions for the torque-off monitor
// bound into dctom_monitor; one clock, rst async high
`default_nettype none
module dctom_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic shutdown_in_chan_a,
   input wire logic shutdown_in_chan_b,
   input wire logic fault_reset,
   input wire logic brake_delay_req,
   input wire logic power_stage_en,
   input wire logic torque_off_err,
   input wire logic discrepancy_err,
   input wire logic brake_release,
   input wire logic fault_reset_ignored
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   property p_one; (!shutdown_in_chan_a || !shutdown_in_chan_b) [*5] |-> !power_stage_en; endproperty
   a_one: assert property (p_one) else $error("enabled");
   property p_two; (!shutdown_in_chan_a && !shutdown_in_chan_b) [*6] |-> torque_off_err || discrepancy_err;
   endproperty
   a_two: assert property (p_two) else $error("no error");
   property p_off; torque_off_err |-> !power_stage_en; endproperty
   a_off: assert property (p_off) else $error("stop");
   property p_hold; torque_off_err && !fault_reset |=> torque_off_err; endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_lat; discrepancy_err |=> discrepancy_err && !power_stage_en; endproperty
   a_lat: assert property (p_lat) else $error("latch");
   property p_ign; discrepancy_err && fault_reset |=> fault_reset_ignored; endproperty
   a_ign: assert property (p_ign) else $error("ignore");
   property p_why; fault_reset_ignored |-> $past(fault_reset) && discrepancy_err; endproperty
   a_why: assert property (p_why) else $error("pulse");
   property p_brk; brake_release == (power_stage_en && !$past(brake_delay_req)); endproperty
   a_brk: assert property (p_brk) else $error("brake");
   cover property ($rose(torque_off_err));
   cover property ($rose(discrepancy_err));
   cover property (fault_reset_ignored);
endmodule
bind dctom_monitor dctom_chk dctom_chk_inst (
   .clk(clk),
   .rst(rst),
   .shutdown_in_chan_a(shutdown_in_chan_a),
   .shutdown_in_chan_b(shutdown_in_chan_b),
   .fault_reset(fault_reset),
   .brake_delay_req(brake_delay_req),
   .power_stage_en(power_stage_en),
   .torque_off_err(torque_off_err),
   .discrepancy_err(discrepancy_err),
   .brake_release(brake_release),
   .fault_reset_ignored(fault_reset_ignored)
);
`default_nettype wire

// File: dctom_monitor_test.sv
// dctom_monitor_test.sv - self-checking bench for the torque-off monitor
// inputs move at falling edges; skew limit cut to 20 cycles
`default_nettype none
module dctom_monitor_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, frst = 1'b0, bdr = 1'b0;
   wire chan_a, chan_b, pse, toe, dse, brk, fri;
   wire [4:0] st;
   int err_total = 0, cmp_count = 0;
   assign st = {pse, toe, dse, brk, fri};
   dctom_relay dctom_relay_inst (.clk(clk), .chan_a(chan_a), .chan_b(chan_b));
   dctom_monitor #(.SKEW_LIMIT_CYC(27'h14)) dctom_monitor_inst (.clk(clk), .rst(rst),
      .shutdown_in_chan_a(chan_a), .shutdown_in_chan_b(chan_b), .fault_reset(frst),
      .brake_delay_req(bdr), .power_stage_en(pse), .torque_off_err(toe),
      .discrepancy_err(dse), .brake_release(brk), .fault_reset_ignored(fri));
   initial forever #5 clk = ~clk;
   task automatic stop_test();
      $display("err_total %0d cmp_count %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [4:0] seen, exp);
      cmp_count++;
      if (seen !== exp) err_total++;
      if (seen !== exp) $display("mismatch %0t %h %h", $time, seen, exp);
   endtask
   // st is enable, stop error, discrepancy, brake, ignored
   task automatic await(input logic [4:0] exp, input int n);
      repeat (n) if (st !== exp) @(negedge clk);
      check(st, exp);
      if (st !== exp) stop_test();
   endtask
   task automatic coord_stop();
      bdr = 1'b1;
      await(5'h10, 8);
      bdr = 1'b0;
      await(5'h12, 2);
      dctom_relay_inst.set(2'h1);
      await(5'h00, 6);
      dctom_relay_inst.set(2'h0);
      await(5'h08, 6);
      frst = 1'b1;
      repeat (3) @(negedge clk);
      await(5'h08, 0);
      frst = 1'b0;
      dctom_relay_inst.set(2'h3);
      repeat (5) @(negedge clk);
      await(5'h08, 0);
      frst = 1'b1;
      await(5'h12, 4);
      frst = 1'b0;
   endtask
   task automatic one_chan();
      bdr = 1'b1;
      await(5'h10, 2);
      dctom_relay_inst.set(2'h2);
      repeat (17) @(negedge clk);
      await(5'h00, 0);
      await(5'h04, 12);
      frst = 1'b1;
      await(5'h05, 3);
      frst = 1'b0;
      bdr = 1'b0;
      dctom_relay_inst.set(2'h3);
      repeat (4) @(negedge clk);
      await(5'h04, 0);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      await(5'h12, 8);
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      coord_stop();
      one_chan();
      stop_test();
   end
endmodule
`default_nettype wire
